// file: pdma_channel.sv
// Current and next buffer pointer/count pair of one transfer direction
`timescale 1ns/1ps
`default_nettype none
`include "pdma_defs.svh"
module pdma_channel
  import pdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_ptr_i,
  input wire logic wr_cnt_i,
  input wire logic wr_nptr_i,
  input wire logic wr_ncnt_i,
  input wire logic [`PDMA_DATA_W-1:0] wdata_i,
  input wire logic step_i,
  input wire logic [1:0] size_i,
  output logic [`PDMA_DATA_W-1:0] ptr_o,
  output logic [`PDMA_CNT_W-1:0] cnt_o,
  output logic [`PDMA_DATA_W-1:0] nptr_o,
  output logic [`PDMA_CNT_W-1:0] ncnt_o,
  output logic end_o,
  output logic end_evt_o,
  output logic drained_o
);
  logic [`PDMA_DATA_W-1:0] ptr_q, nptr_q, incr;
  logic [`PDMA_CNT_W-1:0] cnt_q, ncnt_q;
  logic end_q, chain;

  assign incr = `PDMA_DATA_W'(32'h1 << size_i);
  // Current buffer used up while a next one waits: chain it in
  assign chain = (cnt_q == `PDMA_RST_CNT) && (ncnt_q != `PDMA_RST_CNT) && !wr_cnt_i; // [R16]
  // A software pointer or count write drops the step, so no end event either
  assign end_evt_o = step_i && (cnt_q == `PDMA_CNT_W'(1)) && !wr_cnt_i && !wr_ptr_i; // [R18]

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= `PDMA_RST_WORD;
      cnt_q <= `PDMA_RST_CNT;
    end else if (wr_cnt_i || wr_ptr_i) begin
      if (wr_ptr_i) ptr_q <= wdata_i;
      if (wr_cnt_i) cnt_q <= wdata_i[`PDMA_CNT_W-1:0];
    end else if (step_i) begin
      ptr_q <= ptr_q + incr; // [R17]
      cnt_q <= cnt_q - `PDMA_CNT_W'(1); // [R17]
    end else if (chain) begin
      ptr_q <= nptr_q; // [R16]
      cnt_q <= ncnt_q; // [R16]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nptr_q <= `PDMA_RST_WORD;
      ncnt_q <= `PDMA_RST_CNT;
    end else begin
      if (wr_nptr_i) nptr_q <= wdata_i;
      if (wr_ncnt_i) ncnt_q <= wdata_i[`PDMA_CNT_W-1:0];
      else if (chain && !step_i && !wr_ptr_i) ncnt_q <= `PDMA_RST_CNT; // [R16]
    end
  end

  // End flag: a set wins over a next count write in the same cycle; a current count write blocks the set
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) end_q <= 1'b0;
    else if (end_evt_o) end_q <= 1'b1; // [R18]
    else if (wr_cnt_i || wr_ncnt_i) end_q <= 1'b0; // [R19]
  end

  assign ptr_o = ptr_q;
  assign cnt_o = cnt_q;
  assign nptr_o = nptr_q;
  assign ncnt_o = ncnt_q;
  assign end_o = end_q;
  assign drained_o = (cnt_q == `PDMA_RST_CNT) && (ncnt_q == `PDMA_RST_CNT); // [R18]

endmodule : pdma_channel
`default_nettype wire

// file: pdma_defs.svh
// Register offsets, field positions, reset values and encodings of the DMA channel pair
`ifndef PDMA_DEFS_SVH
`define PDMA_DEFS_SVH

`define PDMA_ADDR_W 12
`define PDMA_DATA_W 32
`define PDMA_CNT_W 16

`define PDMA_OFF_RX_PTR 12'h100
`define PDMA_OFF_RX_CNT 12'h104
`define PDMA_OFF_TX_PTR 12'h108
`define PDMA_OFF_TX_CNT 12'h10c
`define PDMA_OFF_RX_NPTR 12'h110
`define PDMA_OFF_RX_NCNT 12'h114
`define PDMA_OFF_TX_NPTR 12'h118
`define PDMA_OFF_TX_NCNT 12'h11c
`define PDMA_OFF_CTRL 12'h120
`define PDMA_OFF_STAT 12'h124
`define PDMA_OFF_IRQ_STAT 12'h128
`define PDMA_OFF_IRQ_MASK 12'h12c
`define PDMA_OFF_CFG 12'h130

`define PDMA_CTRL_RX_EN 0
`define PDMA_CTRL_RX_DIS 1
`define PDMA_CTRL_TX_EN 8
`define PDMA_CTRL_TX_DIS 9
`define PDMA_STAT_RX_EN 0
`define PDMA_STAT_TX_EN 8

`define PDMA_IRQ_RX_END 0
`define PDMA_IRQ_RX_FULL 1
`define PDMA_IRQ_TX_END 2
`define PDMA_IRQ_TX_EMPTY 3
`define PDMA_IRQ_W 4

`define PDMA_SIZE_BYTE 2'h0
`define PDMA_SIZE_HALF 2'h1
`define PDMA_SIZE_WORD 2'h2
`define PDMA_RST_SIZE 2'h0
`define PDMA_RST_WORD 32'h0000_0000
`define PDMA_RST_CNT 16'h0000

`endif

// file: pdma_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "pdma_defs.svh"
module pdma_irq
  import pdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [`PDMA_IRQ_W-1:0] evt_i,
  input wire logic wr_status_i,
  input wire logic wr_mask_i,
  input wire logic [`PDMA_IRQ_W-1:0] wdata_i,
  output logic [`PDMA_IRQ_W-1:0] status_o,
  output logic [`PDMA_IRQ_W-1:0] mask_o,
  output logic irq_o
);
  logic [`PDMA_IRQ_W-1:0] status_q, mask_q;
  logic irq_q;

  // Write one to clear; a new event in the same cycle keeps its bit set
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) status_q <= '0;
    else status_q <= (status_q & ~(wr_status_i ? wdata_i : '0)) | evt_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) mask_q <= '0;
    else if (wr_mask_i) mask_q <= wdata_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) irq_q <= 1'b0;
    else irq_q <= |(status_q & mask_q);
  end

  assign status_o = status_q;
  assign mask_o = mask_q;
  assign irq_o = irq_q;

endmodule : pdma_irq
`default_nettype wire

// file: pdma_monitor.sv
// Port-level checker for the DMA channel pair, bound into the unit
`timescale 1ns/1ps
`default_nettype none
`include "pdma_defs.svh"
module pdma_monitor
  import pdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [`PDMA_ADDR_W-1:0] reg_addr_i,
  input wire logic [`PDMA_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`PDMA_DATA_W-1:0] reg_rdata_o,
  input wire logic rx_take_o,
  input wire logic tx_ready_i,
  input wire logic [`PDMA_DATA_W-1:0] tx_data_o,
  input wire logic tx_valid_o,
  input var pdma_mem_req_s mem_req_o,
  input wire logic mem_gnt_i,
  input wire logic mem_rvalid_i,
  input wire logic [`PDMA_DATA_W-1:0] mem_rdata_i,
  input wire logic irq_o
);
  logic rx_en_q;
  logic tx_en_q;
  logic [`PDMA_IRQ_W-1:0] mask_q;
  // Enable state as software wrote it; disable wins over enable
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `PDMA_OFF_CTRL) begin
      rx_en_q <= !reg_wdata_i[`PDMA_CTRL_RX_DIS] && (rx_en_q || reg_wdata_i[`PDMA_CTRL_RX_EN]);
      tx_en_q <= !reg_wdata_i[`PDMA_CTRL_TX_DIS] && (tx_en_q || reg_wdata_i[`PDMA_CTRL_TX_EN]);
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= 4'h0;
    end else if (reg_wr_i && reg_addr_i == `PDMA_OFF_IRQ_MASK) begin
      mask_q <= reg_wdata_i[`PDMA_IRQ_W-1:0];
    end
  end
  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  stat_read_a: assert property (reg_rd_i && reg_addr_i == `PDMA_OFF_STAT |=>
    reg_rdata_o == {23'h0, $past(tx_en_q), 7'h0, $past(rx_en_q)})
    else $error("status read does not match enable state");
  rx_gate_a: assert property ($rose(mem_req_o.req) && mem_req_o.we |-> $past(rx_en_q))
    else $error("receive request while receive disabled");
  tx_gate_a: assert property ($rose(mem_req_o.req) && !mem_req_o.we |->
    $past(tx_en_q) && $past(tx_ready_i))
    else $error("transmit request while disabled or not ready");
  req_hold_a: assert property (mem_req_o.req && !mem_gnt_i |=>
    mem_req_o.req && $stable(mem_req_o))
    else $error("memory request changed before grant");
  take_after_a: assert property (mem_req_o.req && mem_req_o.we && mem_gnt_i |=>
    rx_take_o ##1 !rx_take_o)
    else $error("receive take not one cycle after write grant");
  tx_data_a: assert property (mem_rvalid_i |=>
    tx_valid_o && tx_data_o == $past(mem_rdata_i) ##1 !tx_valid_o)
    else $error("transmit word not passed on after read data");
  irq_mask_a: assert property (irq_o |-> $past(mask_q) != 4'h0)
    else $error("interrupt raised with all events masked");
endmodule : pdma_monitor
bind pdma_unit pdma_monitor pdma_monitor_inst (
  .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .rx_take_o, .tx_ready_i, .tx_data_o, .tx_valid_o, .mem_req_o, .mem_gnt_i, .mem_rvalid_i,
  .mem_rdata_i, .irq_o);
`default_nettype wire

// file: pdma_partner.sv
// Behavioural serial peripheral and system memory facing the DMA channel pair
`timescale 1ns/1ps
`default_nettype none
`include "pdma_defs.svh"
module pdma_partner
  import pdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic rx_go_i,
  input wire logic tx_go_i,
  input var pdma_mem_req_s mem_req_i,
  input wire logic rx_take_i,
  input wire logic tx_valid_i,
  output logic mem_gnt_o,
  output logic mem_rvalid_o,
  output logic [`PDMA_DATA_W-1:0] mem_rdata_o,
  output logic rx_ready_o,
  output logic [`PDMA_DATA_W-1:0] rx_data_o,
  output logic tx_ready_o
);
  logic [2:0] dly_q;
  logic [15:0] word_q;
  logic pend_q;
  logic [`PDMA_DATA_W-1:0] raddr_q;
  logic go;
  logic rv;
  // Slow mode lets an answer through once in eight cycles
  assign go = !slow_i || dly_q == 3'h5;
  assign rv = pend_q && !mem_rvalid_o && go;
  // Data lines show the inverted word when no word is offered
  assign rx_data_o = rx_ready_o ? {16'ha5a5, word_q} : ~{16'ha5a5, word_q};
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_q <= 3'h0;
      word_q <= 16'h0;
      pend_q <= 1'b0;
      raddr_q <= 32'h0;
      mem_gnt_o <= 1'b0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= 32'h0;
      rx_ready_o <= 1'b0;
      tx_ready_o <= 1'b0;
    end else begin
      dly_q <= dly_q + 3'h1;
      mem_gnt_o <= mem_req_i.req && !mem_gnt_o && go;
      if (mem_rvalid_o) pend_q <= 1'b0;
      if (mem_req_i.req && mem_gnt_o && !mem_req_i.we) begin
        pend_q <= 1'b1;
        raddr_q <= mem_req_i.addr;
      end
      mem_rvalid_o <= rv;
      mem_rdata_o <= rv ? {raddr_q[15:0], ~raddr_q[15:0]} : ~mem_rdata_o;
      if (rx_take_i) begin
        rx_ready_o <= 1'b0;
        word_q <= word_q + 16'h1;
      end else if (rx_go_i && go) rx_ready_o <= 1'b1;
      if (tx_valid_i) tx_ready_o <= 1'b0;
      else if (tx_go_i && go) tx_ready_o <= 1'b1;
    end
  end
endmodule : pdma_partner
`default_nettype wire

// file: pdma_pkg.sv
// Types shared by the DMA channel pair
`include "pdma_defs.svh"
package pdma_pkg;

  // Request towards the system bus
  typedef struct packed {
    logic req;
    logic we;
    logic [`PDMA_DATA_W-1:0] addr;
    logic [`PDMA_DATA_W-1:0] wdata;
    logic [1:0] size;
  } pdma_mem_req_s;

  typedef enum logic [3:0] {
    PDMA_IDLE = 4'h1,
    PDMA_RX_WR = 4'h2,
    PDMA_TX_RD = 4'h4,
    PDMA_TX_WAIT = 4'h8
  } pdma_state_e;

endpackage : pdma_pkg

// file: pdma_tb.sv
// Self-checking bench for the DMA channel pair
`timescale 1ns/1ps
`default_nettype none
`include "pdma_defs.svh"
module testbench import pdma_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic slow = 1'b0;
  logic rx_go = 1'b0;
  logic tx_go = 1'b0;
  logic [1:0] sz = 2'h0;
  logic [31:0] rdata, rx_data, tx_data, mem_rdata, v;
  logic rx_ready, rx_take, tx_ready, tx_valid, rx_end, tx_end, rx_full, tx_empty;
  logic gnt, rvalid, irq;
  pdma_mem_req_s mem_req;
  integer seed = 46;
  int mismatches = 0;
  int checked = 0;
  logic [31:0] rd_q[$], tx_q[$], wa_q[$], wd_q[$];
  logic [15:0] ctl[10] = '{16'h0001, 16'h0000, 16'h0100, 16'h0002, 16'h0003,
                           16'h0200, 16'h0101, 16'h0300, 16'hfcfc, 16'h0202};
  logic [15:0] st[10] = '{16'h0001, 16'h0001, 16'h0101, 16'h0100, 16'h0100,
                          16'h0000, 16'h0101, 16'h0001, 16'h0001, 16'h0000};
  always #2 clk = ~clk;
  pdma_unit pdma_unit_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_ready_i(rx_ready), .rx_data_i(rx_data),
    .rx_take_o(rx_take), .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .rx_buffer_end_flag_o(rx_end), .tx_buffer_end_flag_o(tx_end),
    .rx_both_buffers_full_flag_o(rx_full), .tx_both_buffers_empty_flag_o(tx_empty),
    .mem_req_o(mem_req), .mem_gnt_i(gnt), .mem_rvalid_i(rvalid), .mem_rdata_i(mem_rdata),
    .irq_o(irq));
  pdma_partner pdma_partner_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .rx_go_i(rx_go), .tx_go_i(tx_go),
    .mem_req_i(mem_req), .rx_take_i(rx_take), .tx_valid_i(tx_valid), .mem_gnt_o(gnt),
    .mem_rvalid_o(rvalid), .mem_rdata_o(mem_rdata), .rx_ready_o(rx_ready),
    .rx_data_o(rx_data), .tx_ready_o(tx_ready));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic drain;
    for (int i = 0; i < 400 && wa_q.size() + tx_q.size() + rd_q.size() > 0; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    check("pending transfers", 32'(wa_q.size() + tx_q.size()), 32'h0);
  endtask : drain
  task automatic results;
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  // Answers are compared against the oldest note as they appear
  always @(posedge clk) begin
    if (rd_seen) check("reg_rdata_o", rdata, rd_q.size() > 0 ? rd_q.pop_front() : ~rdata);
    rd_seen <= rd;
    if (tx_valid) check("tx_data_o", tx_data, tx_q.size() > 0 ? tx_q.pop_front() : ~tx_data);
    if (mem_req.req && gnt) begin
      check("mem addr", mem_req.addr, wa_q.size() > 0 ? wa_q.pop_front() : ~mem_req.addr);
      check("mem size", {30'h0, mem_req.size}, {30'h0, sz});
      if (mem_req.we) check("mem data", mem_req.wdata, wd_q.pop_front());
    end
  end
  initial begin
    #40000;
    mismatches++;
    $display("Error watchdog expected end seen hang");
    results;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rd_reg(12'h100 + 12'(4 * i), 32'h0);
    rd_reg(12'h200, 32'h0);
    check("rx_both_buffers_full_flag_o", {31'h0, rx_full}, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      wr_reg(12'h100 + 12'(4 * i), v);
      rd_reg(12'h100 + 12'(4 * i), i[0] ? {16'h0, v[15:0]} : v);
    end
    for (int i = 7; i >= 0; i--) wr_reg(12'h100 + 12'(4 * i), 32'h0);
    $display("register test done");
    for (int i = 0; i < 10; i++) begin
      wr_reg(`PDMA_OFF_CTRL, {16'h0, ctl[i]});
      rd_reg(`PDMA_OFF_STAT, {16'h0, st[i]});
    end
    rd_reg(`PDMA_OFF_CTRL, 32'h0);
    $display("control test done");
    wr_reg(`PDMA_OFF_IRQ_STAT, 32'hf);
    wr_reg(`PDMA_OFF_CFG, 32'h1);
    sz <= 2'h1;
    wr_reg(`PDMA_OFF_RX_PTR, 32'h1000);
    wr_reg(`PDMA_OFF_RX_CNT, 32'h2);
    wr_reg(`PDMA_OFF_RX_NPTR, 32'h2000);
    wr_reg(`PDMA_OFF_RX_NCNT, 32'h1);
    wa_q = '{32'h1000, 32'h1002, 32'h2000};
    wd_q = '{32'ha5a5_0000, 32'ha5a5_0001, 32'ha5a5_0002};
    slow <= 1'b1;
    rx_go <= 1'b1;
    wr_reg(`PDMA_OFF_CTRL, 32'h1);
    drain;
    rd_reg(`PDMA_OFF_RX_PTR, 32'h2002);
    rd_reg(`PDMA_OFF_RX_CNT, 32'h0);
    rd_reg(`PDMA_OFF_RX_NCNT, 32'h0);
    rd_reg(`PDMA_OFF_IRQ_STAT, 32'h3);
    check("rx_buffer_end_flag_o", {31'h0, rx_end}, 32'h1);
    check("rx_both_buffers_full_flag_o", {31'h0, rx_full}, 32'h1);
    wr_reg(`PDMA_OFF_IRQ_MASK, 32'h4);
    repeat (3) @(posedge clk);
    check("irq_o masked", {31'h0, irq}, 32'h0);
    wr_reg(`PDMA_OFF_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    check("irq_o", {31'h0, irq}, 32'h1);
    wr_reg(`PDMA_OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    check("irq_o cleared", {31'h0, irq}, 32'h0);
    rd_reg(`PDMA_OFF_IRQ_STAT, 32'h2);
    wr_reg(`PDMA_OFF_RX_NCNT, 32'h0);
    repeat (3) @(posedge clk);
    check("rx_buffer_end_flag_o", {31'h0, rx_end}, 32'h0);
    $display("receive test done");
    slow <= 1'b0;
    wr_reg(`PDMA_OFF_CFG, 32'h2);
    sz <= 2'h2;
    wr_reg(`PDMA_OFF_CFG, 32'h3);
    rd_reg(`PDMA_OFF_CFG, 32'h2);
    wr_reg(`PDMA_OFF_TX_PTR, 32'h3000);
    wr_reg(`PDMA_OFF_TX_CNT, 32'h2);
    wa_q = '{32'h3000, 32'h3004};
    tx_q = '{32'h3000_cfff, 32'h3004_cffb};
    tx_go <= 1'b1;
    wr_reg(`PDMA_OFF_CTRL, 32'h100);
    drain;
    rd_reg(`PDMA_OFF_TX_PTR, 32'h3008);
    rd_reg(`PDMA_OFF_TX_CNT, 32'h0);
    check("tx_buffer_end_flag_o", {31'h0, tx_end}, 32'h1);
    check("tx_both_buffers_empty_flag_o", {31'h0, tx_empty}, 32'h1);
    rd_reg(`PDMA_OFF_IRQ_STAT, 32'he);
    repeat (3) @(posedge clk);
    $display("transmit test done");
    results;
  end
endmodule : testbench
`default_nettype wire

// file: pdma_unit.sv
// Peripheral DMA unit: receive and transmit channel pair with register port
//
// Summary of operation
// (R1) Transmit pointer register, 32 bits, read/write
// (R2) Transmit count, 16 low bits
// (R3) Zero transmit count stops transmit transfers
// (R4) Receive next pointer, 32 bits
// (R5) Receive next count, 16 bits
// (R6) Transmit next pointer, 32 bits
// (R7) Transmit next count, 16 bits
// (R8) Control bit 0 enables receive unless disabled
// (R9) Control bit 1 disables receive
// (R10) Control bit 8 enables transmit
// (R11) Control bit 9 disables transmit
// (R12) Status bit 0 shows receive enable
// (R13) Status bit 8 shows transmit enable
// (R14) Control write-only, other bits ignored
// (R15) Transmit enable plus disable means disabled
// (R16) Empty current loads next, clears next count
// (R17) Each transfer advances pointer, decrements count
// (R18) End flag at zero; both-zero flag
// (R19) Count writes clear direction's end flag
`timescale 1ns/1ps
`default_nettype none
`include "pdma_defs.svh"
module pdma_unit
  import pdma_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`PDMA_ADDR_W-1:0] reg_addr_i,
  input wire logic [`PDMA_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`PDMA_DATA_W-1:0] reg_rdata_o,
  // Peripheral side
  input wire logic rx_ready_i,
  input wire logic [`PDMA_DATA_W-1:0] rx_data_i,
  output logic rx_take_o,
  input wire logic tx_ready_i,
  output logic [`PDMA_DATA_W-1:0] tx_data_o,
  output logic tx_valid_o,
  output logic rx_buffer_end_flag_o,
  output logic tx_buffer_end_flag_o,
  output logic rx_both_buffers_full_flag_o,
  output logic tx_both_buffers_empty_flag_o,
  // System bus side
  output var pdma_mem_req_s mem_req_o,
  input wire logic mem_gnt_i,
  input wire logic mem_rvalid_i,
  input wire logic [`PDMA_DATA_W-1:0] mem_rdata_i,
  // Interrupt
  output logic irq_o
);

  pdma_state_e state_q;
  pdma_mem_req_s mem_q;
  logic rx_request_enable_q, tx_request_enable_q;
  logic [1:0] size_q;
  logic [`PDMA_DATA_W-1:0] rdata_q, tx_data_q;
  logic rx_take_q, tx_valid_q;
  logic rx_end_q, tx_end_q, rx_full_q, tx_empty_q;
  logic rx_drained_prev_q, tx_drained_prev_q;

  // Register write decode
  logic wr_rx_ptr, wr_rx_cnt, wr_rx_nptr, wr_rx_ncnt;
  logic wr_tx_ptr, wr_tx_cnt, wr_tx_nptr, wr_tx_ncnt;
  logic wr_ctrl, wr_cfg, wr_irq_stat, wr_irq_mask;

  assign wr_rx_ptr = reg_wr_i && (reg_addr_i == `PDMA_OFF_RX_PTR);
  assign wr_rx_cnt = reg_wr_i && (reg_addr_i == `PDMA_OFF_RX_CNT);
  assign wr_tx_ptr = reg_wr_i && (reg_addr_i == `PDMA_OFF_TX_PTR); // [R1]
  assign wr_tx_cnt = reg_wr_i && (reg_addr_i == `PDMA_OFF_TX_CNT); // [R2]
  assign wr_rx_nptr = reg_wr_i && (reg_addr_i == `PDMA_OFF_RX_NPTR); // [R4]
  assign wr_rx_ncnt = reg_wr_i && (reg_addr_i == `PDMA_OFF_RX_NCNT); // [R5]
  assign wr_tx_nptr = reg_wr_i && (reg_addr_i == `PDMA_OFF_TX_NPTR); // [R6]
  assign wr_tx_ncnt = reg_wr_i && (reg_addr_i == `PDMA_OFF_TX_NCNT); // [R7]
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `PDMA_OFF_CTRL);
  assign wr_cfg = reg_wr_i && (reg_addr_i == `PDMA_OFF_CFG);
  assign wr_irq_stat = reg_wr_i && (reg_addr_i == `PDMA_OFF_IRQ_STAT);
  assign wr_irq_mask = reg_wr_i && (reg_addr_i == `PDMA_OFF_IRQ_MASK);

  // Channel engines
  logic rx_step, tx_step;
  logic [`PDMA_DATA_W-1:0] rx_ptr, rx_nptr, tx_ptr, tx_nptr;
  logic [`PDMA_CNT_W-1:0] rx_cnt, rx_ncnt, tx_cnt, tx_ncnt;
  logic rx_end, tx_end, rx_end_evt, tx_end_evt, rx_drained, tx_drained;

  pdma_channel u_rx_chan (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_ptr_i(wr_rx_ptr),
    .wr_cnt_i(wr_rx_cnt),
    .wr_nptr_i(wr_rx_nptr),
    .wr_ncnt_i(wr_rx_ncnt),
    .wdata_i(reg_wdata_i),
    .step_i(rx_step),
    .size_i(size_q),
    .ptr_o(rx_ptr),
    .cnt_o(rx_cnt),
    .nptr_o(rx_nptr),
    .ncnt_o(rx_ncnt),
    .end_o(rx_end),
    .end_evt_o(rx_end_evt),
    .drained_o(rx_drained)
  );

  pdma_channel u_tx_chan (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_ptr_i(wr_tx_ptr),
    .wr_cnt_i(wr_tx_cnt),
    .wr_nptr_i(wr_tx_nptr),
    .wr_ncnt_i(wr_tx_ncnt),
    .wdata_i(reg_wdata_i),
    .step_i(tx_step),
    .size_i(size_q),
    .ptr_o(tx_ptr),
    .cnt_o(tx_cnt),
    .nptr_o(tx_nptr),
    .ncnt_o(tx_ncnt),
    .end_o(tx_end),
    .end_evt_o(tx_end_evt),
    .drained_o(tx_drained)
  );

  // Interrupt status and mask
  logic [`PDMA_IRQ_W-1:0] irq_evt, irq_status, irq_mask;
  logic irq;

  assign irq_evt[`PDMA_IRQ_RX_END] = rx_end_evt;
  assign irq_evt[`PDMA_IRQ_RX_FULL] = rx_drained && !rx_drained_prev_q;
  assign irq_evt[`PDMA_IRQ_TX_END] = tx_end_evt;
  assign irq_evt[`PDMA_IRQ_TX_EMPTY] = tx_drained && !tx_drained_prev_q;

  pdma_irq u_irq (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .evt_i(irq_evt),
    .wr_status_i(wr_irq_stat),
    .wr_mask_i(wr_irq_mask),
    .wdata_i(reg_wdata_i[`PDMA_IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_drained_prev_q <= 1'b1;
      tx_drained_prev_q <= 1'b1;
    end else begin
      rx_drained_prev_q <= rx_drained;
      tx_drained_prev_q <= tx_drained;
    end
  end

  // Request enables; only the four documented control bits act
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_request_enable_q <= 1'b0;
    end else if (wr_ctrl) begin // [R14]
      if (reg_wdata_i[`PDMA_CTRL_RX_DIS]) rx_request_enable_q <= 1'b0; // [R9]
      else if (reg_wdata_i[`PDMA_CTRL_RX_EN]) rx_request_enable_q <= 1'b1; // [R8]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_request_enable_q <= 1'b0;
    end else if (wr_ctrl) begin // [R14]
      if (reg_wdata_i[`PDMA_CTRL_TX_DIS]) tx_request_enable_q <= 1'b0; // [R11] [R15]
      else if (reg_wdata_i[`PDMA_CTRL_TX_EN]) tx_request_enable_q <= 1'b1; // [R10]
    end
  end

  // Transfer size for both directions
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) size_q <= `PDMA_RST_SIZE;
    else if (wr_cfg && (reg_wdata_i[1:0] != 2'h3)) size_q <= reg_wdata_i[1:0];
  end

  // Transfer sequencing; receive has priority over transmit
  logic rx_go, tx_go;

  // A take or valid pulse just issued blocks the same request for the one cycle it is high, while the peripheral drops its ready
  assign rx_go = rx_request_enable_q && rx_ready_i && !rx_take_q && (rx_cnt != `PDMA_RST_CNT);
  assign tx_go = tx_request_enable_q && tx_ready_i && !tx_valid_q
                 && (tx_cnt != `PDMA_RST_CNT); // [R3]
  assign rx_step = (state_q == PDMA_RX_WR) && mem_gnt_i; // [R17]
  assign tx_step = (state_q == PDMA_TX_WAIT) && mem_rvalid_i; // [R17]

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= PDMA_IDLE;
    end else begin
      case (state_q)
        PDMA_IDLE: begin
          if (rx_go) state_q <= PDMA_RX_WR;
          else if (tx_go) state_q <= PDMA_TX_RD;
        end
        PDMA_RX_WR: begin
          if (mem_gnt_i) state_q <= PDMA_IDLE;
        end
        PDMA_TX_RD: begin
          if (mem_gnt_i) state_q <= PDMA_TX_WAIT;
        end
        PDMA_TX_WAIT: begin
          if (mem_rvalid_i) state_q <= PDMA_IDLE;
        end
        default: state_q <= PDMA_IDLE;
      endcase
    end
  end

  // System bus request, held until granted
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_q <= '0;
    end else if (state_q == PDMA_IDLE) begin
      mem_q.req <= rx_go || tx_go;
      mem_q.we <= rx_go;
      mem_q.addr <= rx_go ? rx_ptr : tx_ptr;
      mem_q.wdata <= rx_go ? rx_data_i : `PDMA_RST_WORD;
      mem_q.size <= size_q;
    end else if (mem_gnt_i) begin
      mem_q.req <= 1'b0;
      mem_q.we <= 1'b0;
    end
  end

  // Peripheral handshake pulses and transmit data
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rx_take_q <= 1'b0;
    else rx_take_q <= rx_step;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= `PDMA_RST_WORD;
    end else begin
      tx_valid_q <= tx_step;
      if (tx_step) tx_data_q <= mem_rdata_i;
    end
  end

  // Flags to the peripheral
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_end_q <= 1'b0;
      tx_end_q <= 1'b0;
      rx_full_q <= 1'b0;
      tx_empty_q <= 1'b0;
    end else begin
      rx_end_q <= rx_end; // [R18]
      tx_end_q <= tx_end; // [R18]
      rx_full_q <= rx_drained; // [R18]
      tx_empty_q <= tx_drained; // [R18]
    end
  end

  // Register read, data in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= `PDMA_RST_WORD;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `PDMA_OFF_RX_PTR: rdata_q <= rx_ptr;
        `PDMA_OFF_RX_CNT: rdata_q <= {16'h0000, rx_cnt};
        `PDMA_OFF_TX_PTR: rdata_q <= tx_ptr; // [R1]
        `PDMA_OFF_TX_CNT: rdata_q <= {16'h0000, tx_cnt}; // [R2]
        `PDMA_OFF_RX_NPTR: rdata_q <= rx_nptr; // [R4]
        `PDMA_OFF_RX_NCNT: rdata_q <= {16'h0000, rx_ncnt}; // [R5]
        `PDMA_OFF_TX_NPTR: rdata_q <= tx_nptr; // [R6]
        `PDMA_OFF_TX_NCNT: rdata_q <= {16'h0000, tx_ncnt}; // [R7]
        `PDMA_OFF_STAT: begin
          rdata_q <= `PDMA_RST_WORD;
          rdata_q[`PDMA_STAT_RX_EN] <= rx_request_enable_q; // [R12]
          rdata_q[`PDMA_STAT_TX_EN] <= tx_request_enable_q; // [R13]
        end
        `PDMA_OFF_IRQ_STAT: rdata_q <= {28'h0000000, irq_status};
        `PDMA_OFF_IRQ_MASK: rdata_q <= {28'h0000000, irq_mask};
        `PDMA_OFF_CFG: rdata_q <= {30'h00000000, size_q};
        default: rdata_q <= `PDMA_RST_WORD; // Control register reads zero [R14]
      endcase
    end else begin
      rdata_q <= `PDMA_RST_WORD;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign rx_take_o = rx_take_q;
  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign rx_buffer_end_flag_o = rx_end_q;
  assign tx_buffer_end_flag_o = tx_end_q;
  assign rx_both_buffers_full_flag_o = rx_full_q;
  assign tx_both_buffers_empty_flag_o = tx_empty_q;
  assign mem_req_o = mem_q;
  assign irq_o = irq;

endmodule : pdma_unit
`default_nettype wire
